// ==== ieg_pkg.sv ====
/*
  Package for the interrupt enable and gating block: register offsets,
  field positions, reset values, source bundles and widths.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package ieg_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (APB word aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] IEG_OFF_CTRL = 8'h00;
  localparam logic [7:0] IEG_OFF_EN0 = 8'h04;
  localparam logic [7:0] IEG_OFF_EN1 = 8'h08;
  localparam logic [7:0] IEG_OFF_EN2 = 8'h0c;
  localparam logic [7:0] IEG_OFF_EN3 = 8'h10;
  localparam logic [7:0] IEG_OFF_EN4 = 8'h14;
  localparam logic [7:0] IEG_OFF_EN5 = 8'h18;
  localparam logic [7:0] IEG_OFF_EN6 = 8'h1c;
  localparam logic [7:0] IEG_OFF_EN7 = 8'h20;
  localparam logic [7:0] IEG_OFF_FLAG0 = 8'h24;
  localparam logic [7:0] IEG_OFF_FLAG1 = 8'h28;
  localparam logic [7:0] IEG_OFF_STAT = 8'h2c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int IEG_GLOBAL_EN_BIT = 7;
  localparam int IEG_GROUP_EN_BIT = 6;
  localparam int IEG_EDGE_BIT = 0;
  localparam logic [7:0] IEG_CTRL_MASK = 8'hc1;
  localparam logic [7:0] IEG_CTRL_RST = 8'h01;

  // ----------------------------------------------------------------
  // Enable register implemented-bit masks, index 0 to 7
  // ----------------------------------------------------------------
  localparam logic [7:0] IEG_EN0_MASK = 8'h31;
  localparam logic [7:0] IEG_EN1_MASK = 8'hc1;
  localparam logic [7:0] IEG_EN2_MASK = 8'h43;
  localparam logic [7:0] IEG_EN3_MASK = 8'hff;
  localparam logic [7:0] IEG_EN4_MASK = 8'h03;
  localparam logic [7:0] IEG_EN5_MASK = 8'hf1;
  localparam logic [7:0] IEG_EN6_MASK = 8'h03;
  localparam logic [7:0] IEG_EN7_MASK = 8'h31;
  localparam logic [7:0] IEG_EN_RST = 8'h00;

  // Group zero source positions
  localparam int IEG_TMR0_BIT = 5;
  localparam int IEG_PINCHG_BIT = 4;
  localparam int IEG_EXT_BIT = 0;

  // Pin select width for the external pin input
  localparam int IEG_PIN_W = 5;
  localparam int IEG_NPINS = 32;
  localparam logic [IEG_PIN_W-1:0] IEG_PINSEL_RST = 5'h00;
  localparam logic [15:0] IEG_VECTOR = 16'h0004;

  // Flags of groups one to seven, laid out as the enable registers
  typedef struct packed {
    logic [7:0] g7;
    logic [7:0] g6;
    logic [7:0] g5;
    logic [7:0] g4;
    logic [7:0] g3;
    logic [7:0] g2;
    logic [7:0] g1;
  } ieg_periph_s;

  // Request to the core sequencer
  typedef struct packed {
    logic req;
    logic [15:0] vector;
  } ieg_core_req_s;

endpackage

// ==== ieg_flag0.sv ====
/*
  Group zero flag register: timer0 overflow, external pin edge flag,
  pin change level. Timer0 and external flags set by hardware, cleared by software writes of zero.
  Assumes source pulses synchronous to pclk.
*/
`timescale 1ns/100ps
module ieg_flag0 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events
  input wire logic tmr0_ovf,
  input wire logic ext_edge,
  input wire logic pin_change,
  // Software clear
  input wire logic clr_we,
  input wire logic [7:0] clr_data,
  // Flag state
  output logic [7:0] flags
);
  import ieg_pkg::*;

  logic tmr0_r;
  logic ext_r;

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr0_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      tmr0_r <= tmr0_ovf | (tmr0_r & ~(clr_we & ~clr_data[IEG_TMR0_BIT]));
      ext_r <= ext_edge | (ext_r & ~(clr_we & ~clr_data[IEG_EXT_BIT]));
    end
  end

  // Pin change flag is a read-only level
  always_comb begin
    flags = 8'h00;
    flags[IEG_TMR0_BIT] = tmr0_r;
    flags[IEG_PINCHG_BIT] = pin_change;
    flags[IEG_EXT_BIT] = ext_r;
  end

endmodule

// ==== ieg_top.sv ====
/*
  Interrupt enable and gating block: control and eight enable registers
  over APB, external pin selection and edge detection, vector request.
  Assumes pin and flag inputs synchronous to pclk, and a core that
  pulses irq_taken once when it accepts a request.
*/
`timescale 1ns/100ps
module ieg_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and peripheral sources
  input wire logic [ieg_pkg::IEG_NPINS-1:0] pins,
  input wire logic tmr0_ovf,
  input wire logic pin_change,
  input wire ieg_pkg::ieg_periph_s periph_flags,
  // Core sequencer
  input wire logic irq_taken,
  input wire logic irq_return,
  output ieg_pkg::ieg_core_req_s core_req
);
  import ieg_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] en_r [0:7];
  logic [IEG_PIN_W-1:0] pinsel_r;
  logic ext_pin_d_r;
  logic ext_pin;
  logic ext_edge;
  logic [7:0] flag0;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] rdata_nxt;
  logic addr_ok;
  logic [7:0] periph_vec [1:7];
  logic grp0_hit;
  logic grp_hit;
  logic flag0_we;
  logic [3:0] en_idx;
  logic [7:0] unimpl_bits;

  // Implemented bits of an enable register by index
  function automatic logic [7:0] en_mask(input int idx);
    case (idx)
      0: en_mask = IEG_EN0_MASK;
      1: en_mask = IEG_EN1_MASK;
      2: en_mask = IEG_EN2_MASK;
      3: en_mask = IEG_EN3_MASK;
      4: en_mask = IEG_EN4_MASK;
      5: en_mask = IEG_EN5_MASK;
      6: en_mask = IEG_EN6_MASK;
      7: en_mask = IEG_EN7_MASK;
      default: en_mask = 8'h00;
    endcase
  endfunction

  // Enable register index from address, eight if not one
  function automatic logic [3:0] en_index(input logic [7:0] a);
    case (a)
      IEG_OFF_EN0: en_index = 4'h0;
      IEG_OFF_EN1: en_index = 4'h1;
      IEG_OFF_EN2: en_index = 4'h2;
      IEG_OFF_EN3: en_index = 4'h3;
      IEG_OFF_EN4: en_index = 4'h4;
      IEG_OFF_EN5: en_index = 4'h5;
      IEG_OFF_EN6: en_index = 4'h6;
      IEG_OFF_EN7: en_index = 4'h7;
      default: en_index = 4'h8;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // APB strobes, zero wait state
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign addr_ok = (en_index(paddr) != 4'h8) || (paddr == IEG_OFF_CTRL) || (paddr == IEG_OFF_FLAG0)
    || (paddr == IEG_OFF_FLAG1) || (paddr == IEG_OFF_STAT);
  assign pslverr = psel & penable & ~addr_ok;
  assign flag0_we = apb_wr && (paddr == IEG_OFF_FLAG0);
  assign en_idx = en_index(paddr);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Software writes, taken interrupt clears global, return sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= IEG_CTRL_RST;
    end else if (irq_taken && ctrl_r[IEG_GLOBAL_EN_BIT]) begin
      ctrl_r[IEG_GLOBAL_EN_BIT] <= 1'b0;
    end else if (irq_return) begin
      ctrl_r[IEG_GLOBAL_EN_BIT] <= 1'b1;
    end else if (apb_wr && (paddr == IEG_OFF_CTRL)) begin
      ctrl_r <= pwdata[7:0] & IEG_CTRL_MASK;
    end
  end

  // Enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        en_r[i] <= IEG_EN_RST;
      end
    end else if (apb_wr && (en_idx != 4'h8)) begin
      en_r[en_idx[2:0]] <= pwdata[7:0] & en_mask(int'(en_idx));
    end
  end

  // External pin select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinsel_r <= IEG_PINSEL_RST;
    end else if (apb_wr && (paddr == IEG_OFF_STAT)) begin
      pinsel_r <= pwdata[IEG_PIN_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // External pin selection and edge detection
  // ----------------------------------------------------------------
  assign ext_pin = pins[pinsel_r];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pin_d_r <= 1'b1; // No false rising edge after reset
    end else begin
      ext_pin_d_r <= ext_pin;
    end
  end

  // Rising when select set, falling when clear
  assign ext_edge = ctrl_r[IEG_EDGE_BIT] ? (ext_pin & ~ext_pin_d_r) : (~ext_pin & ext_pin_d_r);

  // Group zero flags
  ieg_flag0 u_flag0 (
    .pclk(pclk),
    .presetn(presetn),
    .tmr0_ovf(tmr0_ovf),
    .ext_edge(ext_edge),
    .pin_change(pin_change),
    .clr_we(flag0_we),
    .clr_data(pwdata[7:0]),
    .flags(flag0)
  );

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  always_comb begin
    periph_vec[1] = periph_flags.g1;
    periph_vec[2] = periph_flags.g2;
    periph_vec[3] = periph_flags.g3;
    periph_vec[4] = periph_flags.g4;
    periph_vec[5] = periph_flags.g5;
    periph_vec[6] = periph_flags.g6;
    periph_vec[7] = periph_flags.g7;
    grp_hit = 1'b0;
    for (int g = 1; g < 8; g++) begin
      grp_hit = grp_hit | (|(periph_vec[g] & en_r[g]));
    end
  end

  assign grp0_hit = |(flag0 & en_r[0]);

  // Request registered toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req <= '0;
    end else begin
      core_req.req <= ctrl_r[IEG_GLOBAL_EN_BIT] & ~irq_taken
        & (grp0_hit | (ctrl_r[IEG_GROUP_EN_BIT] & grp_hit));
      core_req.vector <= IEG_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered in the setup phase
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr == IEG_OFF_CTRL) begin
      rdata_nxt[7:0] = ctrl_r;
    end else if (en_index(paddr) != 4'h8) begin
      rdata_nxt[7:0] = en_r[en_idx[2:0]];
    end else if (paddr == IEG_OFF_FLAG0) begin
      rdata_nxt[7:0] = flag0;
    end else if (paddr == IEG_OFF_FLAG1) begin
      rdata_nxt = {periph_flags.g4, periph_flags.g3, periph_flags.g2, periph_flags.g1};
    end else if (paddr == IEG_OFF_STAT) begin
      rdata_nxt = {periph_flags.g7, periph_flags.g6, periph_flags.g5, 3'h0, pinsel_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_global_block;
    @(posedge pclk) disable iff (!presetn) !ctrl_r[IEG_GLOBAL_EN_BIT] |=> !core_req.req;
  endproperty
  a_global_block: assert property (p_global_block) else $error("request with global enable clear");

  property p_group_block;
    @(posedge pclk) disable iff (!presetn) (!ctrl_r[IEG_GROUP_EN_BIT] && !grp0_hit) |=> !core_req.req;
  endproperty
  a_group_block: assert property (p_group_block) else $error("peripheral request without group enable");

  property p_grp0_pass;
    @(posedge pclk) disable iff (!presetn) (ctrl_r[IEG_GLOBAL_EN_BIT] && grp0_hit && !irq_taken) |=> core_req.req;
  endproperty
  a_grp0_pass: assert property (p_grp0_pass) else $error("group zero request lost");

  property p_edge_rise;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_r[IEG_EDGE_BIT] && ext_pin && !ext_pin_d_r && !flag0_we) |=> flag0[IEG_EXT_BIT];
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising edge not flagged");

  property p_edge_fall;
    @(posedge pclk) disable iff (!presetn) (!ctrl_r[IEG_EDGE_BIT] && $fell(ext_pin)) |-> ext_edge;
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");

  // Any unimplemented bit held in the control or any enable register
  always_comb begin
    unimpl_bits = ctrl_r & ~IEG_CTRL_MASK;
    for (int g = 0; g < 8; g++) begin
      unimpl_bits = unimpl_bits | (en_r[g] & ~en_mask(g));
    end
  end

  property p_unimpl_zero;
    @(posedge pclk) disable iff (!presetn) unimpl_bits == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_taken_clears;
    @(posedge pclk) disable iff (!presetn)
      (irq_taken && ctrl_r[IEG_GLOBAL_EN_BIT]) |=> !ctrl_r[IEG_GLOBAL_EN_BIT] ##1 !core_req.req;
  endproperty
  a_taken_clears: assert property (p_taken_clears) else $error("global enable not cleared on take");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn) tmr0_ovf |=> flag0[IEG_TMR0_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timer0 flag not set");

  property p_vector;
    @(posedge pclk) disable iff (!presetn) core_req.req |-> (core_req.vector == IEG_VECTOR);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_read_ctrl_unimpl;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && (paddr == IEG_OFF_CTRL)) |-> ((prdata & ~{24'h0, IEG_CTRL_MASK}) == 32'h0);
  endproperty
  a_read_ctrl_unimpl: assert property (p_read_ctrl_unimpl) else $error("control read shows unused bits");

  property p_read_en_unimpl;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && (en_idx != 4'h8)) |-> ((prdata & ~{24'h0, en_mask(int'(en_idx))}) == 32'h0);
  endproperty
  a_read_en_unimpl: assert property (p_read_en_unimpl) else $error("enable read shows unused bits");

  property p_tmr0_pass;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_r[IEG_GLOBAL_EN_BIT] && en_r[0][IEG_TMR0_BIT] && flag0[IEG_TMR0_BIT] && !irq_taken) |=> core_req.req;
  endproperty
  a_tmr0_pass: assert property (p_tmr0_pass) else $error("timer0 request lost");

  property p_pinchg_pass;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_r[IEG_GLOBAL_EN_BIT] && en_r[0][IEG_PINCHG_BIT] && pin_change && !irq_taken) |=> core_req.req;
  endproperty
  a_pinchg_pass: assert property (p_pinchg_pass) else $error("pin change request lost");

  property p_ext_pass;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_r[IEG_GLOBAL_EN_BIT] && en_r[0][IEG_EXT_BIT] && flag0[IEG_EXT_BIT] && !irq_taken) |=> core_req.req;
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("external pin request lost");

  property p_group_pass;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_r[IEG_GLOBAL_EN_BIT] && ctrl_r[IEG_GROUP_EN_BIT] && grp_hit && !irq_taken) |=> core_req.req;
  endproperty
  a_group_pass: assert property (p_group_pass) else $error("peripheral request lost");

  property p_no_rise_on_fall;
    @(posedge pclk) disable iff (!presetn) (!ctrl_r[IEG_EDGE_BIT] && $rose(ext_pin)) |-> !ext_edge;
  endproperty
  a_no_rise_on_fall: assert property (p_no_rise_on_fall) else $error("rising edge taken in falling mode");

  property p_no_fall_on_rise;
    @(posedge pclk) disable iff (!presetn) (ctrl_r[IEG_EDGE_BIT] && $fell(ext_pin)) |-> !ext_edge;
  endproperty
  a_no_fall_on_rise: assert property (p_no_fall_on_rise) else $error("falling edge taken in rising mode");

  property p_ext_flag_set;
    @(posedge pclk) disable iff (!presetn) ext_edge |=> flag0[IEG_EXT_BIT];
  endproperty
  a_ext_flag_set: assert property (p_ext_flag_set) else $error("external pin flag not set");

  property p_taken_drop;
    @(posedge pclk) disable iff (!presetn) irq_taken |=> !core_req.req;
  endproperty
  a_taken_drop: assert property (p_taken_drop) else $error("request still up after take");

  property p_return_sets;
    @(posedge pclk) disable iff (!presetn) (irq_return && !irq_taken) |=> ctrl_r[IEG_GLOBAL_EN_BIT];
  endproperty
  a_return_sets: assert property (p_return_sets) else $error("return did not set global enable");

endmodule

// ==== ieg_core_model.sv ====
/*
  Core sequencer model: accepts vector requests after a set delay and
  optionally returns from the service routine a few cycles later.
  Assumes the request struct of ieg_pkg and the single pclk domain.
*/
`timescale 1ns/100ps
module ieg_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the block
  input wire ieg_pkg::ieg_core_req_s core_req,
  // Bench controls
  input wire logic ack_en,
  input wire logic ret_en,
  input wire logic [3:0] ack_delay,
  // Answers to the block, and the taken count for the bench
  output logic irq_taken,
  output logic irq_return,
  output logic [7:0] taken_cnt
);
  import ieg_pkg::*;
  // Accept a standing request, then maybe return
  initial begin
    irq_taken = 1'b0;
    irq_return = 1'b0;
    taken_cnt = 8'h00;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && ack_en === 1'b1 && core_req.req === 1'b1) begin
        repeat (ack_delay) @(posedge pclk);
        if (core_req.req === 1'b1) begin
          irq_taken <= 1'b1;
          taken_cnt <= taken_cnt + 8'h01;
          @(posedge pclk);
          irq_taken <= 1'b0;
          // Let the dropped request show before looking again
          @(posedge pclk);
          if (ret_en === 1'b1) begin
            repeat (4) @(posedge pclk);
            irq_return <= 1'b1;
            @(posedge pclk);
            irq_return <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ==== tb_interrupt_enable_gating.sv ====
/*
  Self-checking bench for the interrupt enable and gating block.
  Assumes ieg_top with its APB slave and the ieg_core_model partner.
*/
`timescale 1ns/100ps
module tb_interrupt_enable_gating;
  import ieg_pkg::*;
  // ----------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq_taken, irq_return, e;
  logic tmr0_ovf = 1'b0, pin_change = 1'b0, ack_en = 1'b0, ret_en = 1'b0;
  logic [IEG_NPINS-1:0] pins = '0;
  ieg_periph_s periph_flags = '0;
  ieg_core_req_s core_req;
  logic [7:0] taken_cnt, v;
  logic [3:0] ack_delay = 4'h7;
  int error_cnt = 0, check_count = 0, k, idx, p, q;
  logic [7:0] mask_m [9] = '{8'hc1, 8'h31, 8'hc1, 8'h43, 8'hff, 8'h03, 8'hf1, 8'h03, 8'h31};
  logic [7:0] reg_m [9];

  always #2.5 pclk = ~pclk;

  ieg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .tmr0_ovf(tmr0_ovf), .pin_change(pin_change), .periph_flags(periph_flags), .irq_taken(irq_taken),
    .irq_return(irq_return), .core_req(core_req));
  ieg_core_model u_core (.pclk(pclk), .presetn(presetn), .core_req(core_req), .ack_en(ack_en),
    .ret_en(ret_en), .ack_delay(ack_delay), .irq_taken(irq_taken), .irq_return(irq_return),
    .taken_cnt(taken_cnt));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_reg(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), {24'h0, d});
    reg_m[i] = d & mask_m[i];
  endtask
  task automatic wait_cnt(input logic [7:0] c);
    for (int i = 0; i < 100 && taken_cnt !== c; i++) @(posedge pclk);
  endtask
  // Reference request from control, enables and flags
  function automatic logic exp_req(input logic [7:0] f0);
    logic grp;
    grp = 1'b0;
    for (int i = 0; i < 7; i++) grp |= |(reg_m[i + 2] & periph_flags[8 * i +: 8]);
    return reg_m[0][7] & ((|(reg_m[1] & f0)) | (reg_m[0][6] & grp));
  endfunction
  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(32'h2d492326));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then all ones and all zeros
    for (k = 0; k < 9; k++) begin
      reg_m[k] = (k == 0) ? 8'h01 : 8'h00;
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd, {24'h0, reg_m[k]});
      wr_reg(k, 8'hff);
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd, {24'h0, mask_m[k]});
      wr_reg(k, 8'h00);
    end
    chk({16'h0, core_req.vector}, 32'h4);
    apb(1'b1, 8'h40, 32'hff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Random enables and flags against the reference
    for (k = 0; k < 300; k++) begin
      idx = $urandom_range(0, 8);
      v = 8'($urandom);
      if (idx == 0 && k[1:0] != 2'b00) v[7] = 1'b1;
      wr_reg(idx, v);
      periph_flags <= 56'({$urandom, $urandom});
      pin_change <= 1'($urandom);
      repeat (3) @(posedge pclk);
      chk({31'h0, core_req.req}, {31'h0, exp_req({3'b0, pin_change, 4'b0})});
    end
    periph_flags <= '0;
    pin_change <= 1'b0;
    for (k = 0; k < 9; k++) wr_reg(k, 8'h00);
    // Timer0 flag with global enable off, then taken twice
    wr_reg(1, 8'h20);
    tmr0_ovf <= 1'b1;
    @(posedge pclk);
    tmr0_ovf <= 1'b0;
    apb(1'b0, IEG_OFF_FLAG0, 32'h0);
    chk(rd, 32'h20);
    chk({31'h0, core_req.req}, 32'h0);
    ack_en <= 1'b1;
    ret_en <= 1'b1;
    wr_reg(0, 8'h80);
    wait_cnt(8'h01);
    ack_delay <= 4'h0;
    repeat (2) @(posedge pclk);
    chk({31'h0, core_req.req}, 32'h0);
    apb(1'b0, IEG_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    wait_cnt(8'h02);
    ack_en <= 1'b0;
    repeat (12) @(posedge pclk);
    chk({31'h0, core_req.req}, 32'h1);
    chk({24'h0, taken_cnt}, 32'h2);
    ret_en <= 1'b0;
    apb(1'b1, IEG_OFF_FLAG0, 32'h0);
    wr_reg(0, 8'h00);
    // External pin: chosen pin and chosen edge only
    wr_reg(1, 8'h01);
    for (k = 0; k < 4; k++) begin
      e = k[0];
      p = $urandom_range(0, 31);
      q = (p + 1) % 32;
      apb(1'b1, IEG_OFF_STAT, 32'(p));
      wr_reg(0, {7'h0, e});
      pins <= {IEG_NPINS{~e}};
      repeat (4) @(posedge pclk);
      apb(1'b1, IEG_OFF_FLAG0, 32'h0);
      pins[q] <= e;
      repeat (4) @(posedge pclk);
      apb(1'b0, IEG_OFF_FLAG0, 32'h0);
      chk(rd, 32'h0);
      pins[p] <= e;
      repeat (4) @(posedge pclk);
      apb(1'b0, IEG_OFF_FLAG0, 32'h0);
      chk(rd, 32'h1);
      wr_reg(0, {1'b1, 6'h0, e});
      repeat (3) @(posedge pclk);
      chk({31'h0, core_req.req}, 32'h1);
      apb(1'b1, IEG_OFF_FLAG0, 32'h0);
      pins[p] <= ~e;
      repeat (4) @(posedge pclk);
      apb(1'b0, IEG_OFF_FLAG0, 32'h0);
      chk(rd, 32'h0);
    end
    // Mid-run reset returns control and enables to reset values
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IEG_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, IEG_OFF_EN0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, core_req.req}, 32'h0);
    final_report();
  end
endmodule
